// [src/cmc_defines.vh]
/*
 Constants of the CAN mode control and status block: register
 indexes, field positions, reset values and bit-time counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CMC_DEFINES_VH
`define CMC_DEFINES_VH

// register indexes, byte address is four times the index
`define CMC_IDX_MCTL 10'h000
`define CMC_IDX_GSTAT 10'h002
`define CMC_IDX_BITP 10'h004

// master_control fields
`define CMC_MC_REORDER 15
`define CMC_MC_AUTOHALT 14
`define CMC_MC_TEST_HI 10
`define CMC_MC_TEST_LO 8
`define CMC_MC_AUTOWAKE 7
`define CMC_MC_HIBO 6
`define CMC_MC_SLEEP 5
`define CMC_MC_TXORD 2
`define CMC_MC_HALT 1
`define CMC_MC_RESET 0

// general_status fields
`define CMC_GS_EP 5
`define CMC_GS_HS 4
`define CMC_GS_RST 3
`define CMC_GS_TIP 2
`define CMC_GS_BO 0

// reset values
`define CMC_TEST_RST 3'h0
`define CMC_BITP_RST 16'h0014

// bit-time counts
`define CMC_JOIN_BITS 4'hB
`define CMC_WAKE_BITS 2'h2

// time-triggered mailbox range excluded from index ordering
`define CMC_TT_LO 24
`define CMC_TT_HI 30

`endif

// [src/cmc_bus_watch.v]
/*
 Receive pin watcher: three-stage synchroniser with agreement
 filter, plus a run counter of consecutive recessive bits.
 Assumes bit_en is a one-cycle pulse once per CAN bit time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.vh"

module cmc_bus_watch (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // pin and timing
    input wire can_rx,
    input wire bit_en,
    input wire restart,
    // results
    output reg rx_dominant,
    output reg recessive_run_done
);

    reg sync1_r;
    reg sync2_r;
    reg sync3_r;
    reg [3:0] run_r;

    // first stage feeds only the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
            rx_dominant <= 1'b0;
        end else begin
            sync1_r <= can_rx;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            if (sync2_r == sync3_r) begin
                rx_dominant <= ~sync3_r;
            end
        end
    end

    // any dominant bit restarts the recessive run
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 4'h0;
            recessive_run_done <= 1'b0;
        end else if (restart) begin
            run_r <= 4'h0;
            recessive_run_done <= 1'b0;
        end else if (bit_en) begin
            if (rx_dominant) begin
                run_r <= 4'h0;
                recessive_run_done <= 1'b0;
            end else if (run_r != `CMC_JOIN_BITS) begin
                run_r <= run_r + 4'h1;
                recessive_run_done <= (run_r + 4'h1 == `CMC_JOIN_BITS);
            end
        end
    end

endmodule
`default_nettype wire

// [src/cmc_mode_ctrl.v]
/*
 CAN mode control and general status: APB slave holding
 master_control, general_status and a bit period register,
 the mode state machine and transmit order selection.
 Assumes a protocol engine that reports bus events as
 single-cycle pulses or levels on pclk.
*/
// Register access over APB was left to the implementer.
// How it works
// - control registers take 16-bit word writes only
// - reorder bit reorders identifier fields
// - bus-off entry sets halt when both enabled
// - reserved control bits read zero
// - auto-wake ends sleep on dominant bit
// - some bits change only in reset/halt
// - halt in bus off within one bit
// - sleep freezes error counters, ignores bus
// - eleven recessive bits after sleep exit
// - only two registers reachable in sleep
// - index order from mailbox 31 downward; the code stops at mailbox 1 and never picks mailbox 0
// - otherwise lowest arbitration field first
// - halt finishes operation, then leaves bus
// - halt at idle within one bit
// - eleven recessive bits after halt cleared
// - reset request rising edge reinitialises all
// - power-on sets reset request and status
// - error passive flag held through bus off
// - engine leaves sleep two bits later
// - transmit flag covers tx and bus off
// - transmit flag cleared by other events
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.vh"

module cmc_mode_ctrl (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // can receive pin
    input wire can_rx,
    // protocol engine events
    input wire eng_bus_idle,
    input wire eng_busoff,
    input wire eng_ep_enter,
    input wire eng_ea_enter,
    input wire eng_tx_start,
    input wire eng_im3,
    input wire eng_more_pend,
    input wire eng_arb_lost,
    input wire eng_rx_start,
    // transmit queue
    input wire [31:0] tx_pending_bits,
    input wire tt_enable,
    input wire [4:0] arb_pick,
    input wire arb_pick_valid,
    // controls to engine and mailboxes
    output reg id_field_reorder,
    output reg [2:0] test_mode_select,
    output reg bus_join,
    output reg hold_counters,
    output reg soft_reset,
    output reg busoff_recover,
    output reg mode_change_set,
    output reg [4:0] next_mbox,
    output reg next_mbox_valid
);

    localparam ST_RESET = 3'd0;
    localparam ST_JOIN = 3'd1;
    localparam ST_ACTIVE = 3'd2;
    localparam ST_HPEND = 3'd3;
    localparam ST_HALT = 3'd4;
    localparam ST_SLEEP = 3'd5;
    localparam ST_WAKE = 3'd6;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg auto_halt_on_busoff;
    reg auto_wake_enable;
    reg halt_in_busoff_enable;
    reg sleep_request;
    reg tx_order_select;
    reg halt_request;
    reg reset_request;
    reg error_passive_flag;
    reg tip_r;
    reg busoff_q_r;
    reg [15:0] bitp_r;
    reg [15:0] bitcnt_r;
    reg bit_en_r;
    reg [1:0] wake_cnt_r;
    reg err_r;
    wire rx_dom;
    wire rec_done;
    wire join_restart;

    // one register index hit, used across the decode
    function hit;
        input [11:0] addr;
        input [9:0] idx;
        begin
            hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
        end
    endfunction

    // highest pending index from 31 down to 1
    function [5:0] pick_top;
        input [31:0] vec;
        integer i;
        begin
            pick_top = 6'h00;
            for (i = 1; i < 32; i = i + 1) begin
                if (vec[i]) begin
                    pick_top = {1'b1, i[4:0]};
                end
            end
        end
    endfunction

    // access decode
    wire sel_mctl = hit(paddr, `CMC_IDX_MCTL);
    wire sel_gstat = hit(paddr, `CMC_IDX_GSTAT);
    wire sel_bitp = hit(paddr, `CMC_IDX_BITP);
    wire in_sleep = (state_r == ST_SLEEP) || (state_r == ST_WAKE);
    wire mapped = sel_mctl || sel_gstat || sel_bitp;
    wire blocked = in_sleep && sel_bitp;
    wire bad_size = pwrite && (pstrb[1:0] != 2'b11);
    wire acc_err = !mapped || blocked || bad_size;
    wire setup_ph = psel && !penable && !pready;
    wire wr_go = psel && penable && pready && pwrite && !err_r;
    wire wr_mctl = wr_go && sel_mctl;
    wire rst_rise = wr_mctl && pwdata[`CMC_MC_RESET] && !reset_request;
    wire busoff_rise = eng_busoff && !busoff_q_r;

    // mode views
    wire in_rst = (state_r == ST_RESET);
    wire in_halt = (state_r == ST_HALT);
    wire halted = in_halt || in_sleep || in_rst;

    // read mux, reserved bits come back zero
    wire [15:0] mctl_rd = {id_field_reorder, auto_halt_on_busoff, 3'h0, test_mode_select,
                           auto_wake_enable, halt_in_busoff_enable, sleep_request, 2'h0,
                           tx_order_select, halt_request, reset_request};
    wire [15:0] gstat_rd = {10'h000, error_passive_flag, halted && !in_rst, in_rst,
                            tip_r || eng_busoff, 1'b0, eng_busoff};

    // apb answer one cycle after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            err_r <= 1'b0;
        end else if (setup_ph) begin
            pready <= 1'b1;
            pslverr <= acc_err;
            err_r <= acc_err;
            if (acc_err || pwrite) begin
                prdata <= 32'h00000000;
            end else if (sel_mctl) begin
                prdata <= {16'h0000, mctl_rd};
            end else if (sel_gstat) begin
                prdata <= {16'h0000, gstat_rd};
            end else begin
                prdata <= {16'h0000, bitp_r};
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            err_r <= 1'b0;
        end
    end

    // master_control fields; hardware sets win over writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_field_reorder <= 1'b0;
            auto_halt_on_busoff <= 1'b0;
            test_mode_select <= `CMC_TEST_RST;
            auto_wake_enable <= 1'b0;
            halt_in_busoff_enable <= 1'b0;
            sleep_request <= 1'b0;
            tx_order_select <= 1'b0;
            halt_request <= 1'b0;
            reset_request <= 1'b1;
            bitp_r <= `CMC_BITP_RST;
        end else if (rst_rise) begin
            id_field_reorder <= 1'b0;
            auto_halt_on_busoff <= 1'b0;
            test_mode_select <= `CMC_TEST_RST;
            auto_wake_enable <= 1'b0;
            halt_in_busoff_enable <= 1'b0;
            sleep_request <= 1'b0;
            tx_order_select <= 1'b0;
            halt_request <= 1'b0;
            reset_request <= 1'b1;
            bitp_r <= `CMC_BITP_RST;
        end else begin
            if (wr_mctl) begin
                reset_request <= pwdata[`CMC_MC_RESET];
                // test mode trusts software to halt first
                test_mode_select <= pwdata[`CMC_MC_TEST_HI:`CMC_MC_TEST_LO];
                if (in_rst) begin
                    id_field_reorder <= pwdata[`CMC_MC_REORDER];
                    auto_halt_on_busoff <= pwdata[`CMC_MC_AUTOHALT];
                end
                if (in_rst || in_halt) begin
                    auto_wake_enable <= pwdata[`CMC_MC_AUTOWAKE];
                    halt_in_busoff_enable <= pwdata[`CMC_MC_HIBO];
                    tx_order_select <= pwdata[`CMC_MC_TXORD];
                end
                if (!pwdata[`CMC_MC_SLEEP]) begin
                    sleep_request <= 1'b0;
                end else if (in_halt) begin
                    sleep_request <= 1'b1;
                end
                if (pwdata[`CMC_MC_HALT]) begin
                    halt_request <= 1'b1;
                end else if (halted) begin
                    halt_request <= 1'b0;
                end
            end
            if (wr_go && sel_bitp && in_rst) begin
                bitp_r <= pwdata[15:0];
            end
            if (state_r == ST_SLEEP && auto_wake_enable && rx_dom) begin
                sleep_request <= 1'b0;
            end
            if (busoff_rise && auto_halt_on_busoff && halt_in_busoff_enable) begin
                halt_request <= 1'b1;
            end
        end
    end

    // bit time divider, one pulse per bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bitcnt_r <= 16'h0000;
            bit_en_r <= 1'b0;
        end else if (bitcnt_r == 16'h0000) begin
            bitcnt_r <= (bitp_r == 16'h0000) ? 16'h0000 : bitp_r - 16'h0001;
            bit_en_r <= 1'b1;
        end else begin
            bitcnt_r <= bitcnt_r - 16'h0001;
            bit_en_r <= 1'b0;
        end
    end

    // the recessive run starts afresh on every join attempt
    assign join_restart = (state_r != ST_JOIN);

    cmc_bus_watch u_watch (
        .pclk(pclk),
        .presetn(presetn),
        .can_rx(can_rx),
        .bit_en(bit_en_r),
        .restart(join_restart),
        .rx_dominant(rx_dom),
        .recessive_run_done(rec_done)
    );

    // mode state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: begin
                if (!reset_request) begin
                    state_nxt = ST_JOIN;
                end
            end
            ST_JOIN: begin
                if (halt_request) begin
                    state_nxt = ST_HALT;
                end else if (rec_done) begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (halt_request) begin
                    state_nxt = ST_HPEND;
                end
            end
            ST_HPEND: begin
                if (bit_en_r) begin
                    if (eng_busoff && halt_in_busoff_enable) begin
                        state_nxt = ST_HALT;
                    end else if (!eng_busoff && eng_bus_idle) begin
                        state_nxt = ST_HALT;
                    end
                end
            end
            ST_HALT: begin
                if (sleep_request) begin
                    state_nxt = ST_SLEEP;
                end else if (!halt_request) begin
                    state_nxt = ST_JOIN;
                end
            end
            ST_SLEEP: begin
                if (!sleep_request) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (bit_en_r && wake_cnt_r == `CMC_WAKE_BITS - 2'h1) begin
                    state_nxt = halt_request ? ST_HALT : ST_JOIN;
                end
            end
            default: begin
                state_nxt = ST_RESET;
            end
        endcase
        if (reset_request || rst_rise) begin
            state_nxt = ST_RESET;
        end
    end

    // state, wake count and engine pulses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RESET;
            wake_cnt_r <= 2'h0;
            soft_reset <= 1'b0;
            busoff_recover <= 1'b0;
            mode_change_set <= 1'b0;
            busoff_q_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busoff_q_r <= eng_busoff;
            soft_reset <= rst_rise;
            busoff_recover <= (state_r == ST_HPEND) && (state_nxt == ST_HALT) && eng_busoff;
            mode_change_set <= rst_rise ||
                               ((state_nxt == ST_HALT) && (state_r == ST_HPEND || state_r == ST_JOIN));
            if (state_r != ST_WAKE) begin
                wake_cnt_r <= 2'h0;
            end else if (bit_en_r) begin
                wake_cnt_r <= wake_cnt_r + 2'h1;
            end
        end
    end

    // engine-facing levels from the settled mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_join <= 1'b0;
            hold_counters <= 1'b0;
        end else begin
            bus_join <= (state_nxt == ST_ACTIVE) || (state_nxt == ST_HPEND);
            hold_counters <= (state_nxt == ST_SLEEP) || (state_nxt == ST_WAKE);
        end
    end

    // error passive flag survives bus off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_passive_flag <= 1'b0;
        end else if (eng_ep_enter) begin
            error_passive_flag <= 1'b1;
        end else if (eng_ea_enter || rst_rise || busoff_recover) begin
            error_passive_flag <= 1'b0;
        end
    end

    // transmit in progress; a start wins over any clear
    wire tip_clr = (eng_im3 && !eng_more_pend) || eng_arb_lost || eng_bus_idle ||
                   eng_rx_start || rst_rise || (state_r != state_nxt && state_nxt == ST_HALT);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tip_r <= 1'b0;
        end else if (eng_tx_start) begin
            tip_r <= 1'b1;
        end else if (tip_clr) begin
            tip_r <= 1'b0;
        end
    end

    // transmit order selection
    wire [31:0] tt_mask = tt_enable ? 32'h7F000000 : 32'h00000000;
    wire [5:0] top = pick_top(tx_pending_bits & ~tt_mask);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_mbox <= 5'h00;
            next_mbox_valid <= 1'b0;
        end else if (tx_order_select) begin
            next_mbox <= top[4:0];
            next_mbox_valid <= top[5];
        end else begin
            next_mbox <= arb_pick;
            next_mbox_valid <= arb_pick_valid;
        end
    end

    // identifier field order, applied by mailbox and filter logic
    // (driven from the master_control field directly)

endmodule
`default_nettype wire

// [bench/cmc_mode_ctrl_properties.sv]
/*
 Checker for the CAN mode control block, watching only its ports.
 Assumes a single pclk domain and binding onto cmc_mode_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // bus and engine
    input wire logic can_rx,
    input wire logic eng_busoff,
    // controls
    input wire logic id_field_reorder,
    input wire logic bus_join,
    input wire logic hold_counters,
    input wire logic soft_reset,
    input wire logic busoff_recover,
    input wire logic mode_change_set
);
    logic [7:0] rec_cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // recessive run length in pclk cycles, saturating
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) rec_cnt <= 8'h00;
        else if (!can_rx) rec_cnt <= 8'h00;
        else if (rec_cnt != 8'hFF) rec_cnt <= rec_cnt + 8'h01;
    end
    property p_word_err; psel && !penable && pwrite && pstrb[1:0] != 2'h3 |=> pslverr; endproperty
    a_word_err: assert property (p_word_err) else $error("short write not refused");
    property p_resv; pready && !pwrite && paddr == 12'h000 |-> prdata[13:11] == 3'h0 && prdata[4:3] == 2'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved control bits read nonzero");
    property p_reorder; $changed(id_field_reorder) |-> $past(psel && penable && pwrite && paddr == 12'h000);
    endproperty
    a_reorder: assert property (p_reorder) else $error("reorder changed without a write");
    property p_soft; soft_reset |=> !soft_reset && !bus_join; endproperty
    a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
    property p_mchg; mode_change_set |=> !mode_change_set; endproperty
    a_mchg: assert property (p_mchg) else $error("mode change pulse too long");
    property p_recover; busoff_recover |-> $past(eng_busoff); endproperty
    a_recover: assert property (p_recover) else $error("recover without bus off");
    property p_hold; hold_counters |-> !bus_join; endproperty
    a_hold: assert property (p_hold) else $error("joined while counters held");
    // margin of three cycles for the pin synchroniser
    property p_join; $rose(bus_join) |-> rec_cnt >= 8'h08; endproperty
    a_join: assert property (p_join) else $error("joined without recessive run");
    c_soft: cover property (soft_reset);
    c_recover: cover property (busoff_recover);
    c_join: cover property ($rose(bus_join));
endmodule
bind cmc_mode_ctrl cmc_mode_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx(can_rx), .eng_busoff(eng_busoff), .id_field_reorder(id_field_reorder), .bus_join(bus_join),
    .hold_counters(hold_counters), .soft_reset(soft_reset), .busoff_recover(busoff_recover),
    .mode_change_set(mode_change_set));
`default_nettype wire

// [bench/cmc_can_node.sv]
/*
 Far-side CAN node: sends a short frame starting with a dominant
 bit on request. Assumes bit_cycles matches the block's bit time.
*/
`timescale 1ns/1ps
`default_nettype none
module cmc_can_node (
    // clock
    input wire logic pclk,
    // bench control
    input wire logic start,
    input wire logic [7:0] bit_cycles,
    // bus pin, high is recessive
    output logic can_rx
);
    logic [7:0] frame_r = 8'h00;
    logic [3:0] left_r = 4'h0;
    logic [7:0] tick_r = 8'h00;
    // shift the frame lsb first, dominant start bit first
    always @(posedge pclk) begin
        if (start) begin
            frame_r <= 8'h32;
            left_r <= 4'h8;
            tick_r <= 8'h00;
        end else if (left_r != 4'h0) begin
            if (tick_r == bit_cycles - 8'h01) begin
                tick_r <= 8'h00;
                frame_r <= frame_r >> 1;
                left_r <= left_r - 4'h1;
            end else tick_r <= tick_r + 8'h01;
        end
    end
    // a released bus floats recessive
    assign can_rx = (left_r != 4'h0) ? frame_r[0] : 1'b1;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
/*
 Testbench of the CAN mode control block: APB tasks, engine events
 and a far-side node. Assumes 0x000/0x008/0x010 register map.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, can_rx, node_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, pend;
    logic [3:0] pstrb;
    logic [4:0] ev, arb_pick, next_mbox;
    logic bus_idle, busoff, tt_enable, pick_valid, reorder, join_w, hold, sreset, recover, mchg, nm_valid;
    logic [2:0] tmode;
    int n_mismatch = 0;
    int total_checks = 0;

    cmc_mode_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .can_rx(can_rx), .eng_bus_idle(bus_idle), .eng_busoff(busoff), .eng_ep_enter(ev[0]),
        .eng_ea_enter(ev[1]), .eng_tx_start(ev[2]), .eng_im3(ev[3]), .eng_more_pend(1'b0),
        .eng_arb_lost(ev[4]), .eng_rx_start(1'b0), .tx_pending_bits(pend), .tt_enable(tt_enable),
        .arb_pick(arb_pick), .arb_pick_valid(pick_valid), .id_field_reorder(reorder),
        .test_mode_select(tmode), .bus_join(join_w), .hold_counters(hold), .soft_reset(sreset),
        .busoff_recover(recover), .mode_change_set(mchg), .next_mbox(next_mbox), .next_mbox_valid(nm_valid));
    cmc_can_node node (.pclk(pclk), .start(node_start), .bit_cycles(8'h04), .can_rx(can_rx));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer; holds the request until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_of_test;
        end
        rdv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next call never re-drives psel in this step
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        chk(rdv, exp);
    endtask
    // bounded wait for bus_join (0) or hold_counters (1)
    task wt(input int which, input logic val, input int bound);
        int n;
        logic s;
        n = 0;
        s = ~val;
        while (s !== val && n < bound) begin
            @(posedge pclk);
            s = (which == 0) ? join_w : hold;
            n++;
        end
        chk({31'h0, s}, {31'h0, val});
        if (s !== val) end_of_test;
    endtask
    task pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge pclk);
        ev <= 5'h00;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        ev = 5'h00;
        bus_idle = 1'b1;
        busoff = 1'b0;
        tt_enable = 1'b0;
        pick_valid = 1'b0;
        pend = 32'h0;
        arb_pick = 5'h00;
        node_start = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h0001);
        rd(12'h008, 32'h0008);
        apb(1'b1, 12'h000, 16'hFFFF);
        chk({29'h0, tmode}, 32'h7);
        rd(12'h000, 32'hC7C7);
        chk({29'h0, reorder, 2'h0}, 32'h4);
        pstrb <= 4'h1;
        apb(1'b1, 12'h000, 16'h0001);
        chk({31'h0, perr}, 32'h1);
        pstrb <= 4'hF;
        rd(12'h000, 32'hC7C7);
        apb(1'b0, 12'h0FC, 16'h0000);
        chk({31'h0, perr}, 32'h1);
        // transmit order, index then internal arbitration
        apb(1'b1, 12'h000, 16'h0005);
        pend <= 32'h4000_0006;
        repeat (3) @(posedge pclk);
        chk({26'h0, nm_valid, next_mbox}, 32'h3E);
        tt_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({27'h0, next_mbox}, 32'h02);
        apb(1'b1, 12'h000, 16'h0001);
        arb_pick <= 5'h09;
        pick_valid <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({27'h0, next_mbox}, 32'h09);
        // join after eleven recessive bits
        apb(1'b1, 12'h010, 16'h0004);
        apb(1'b1, 12'h000, 16'h0000);
        chk({31'h0, join_w}, 32'h0);
        wt(0, 1'b1, 400);
        apb(1'b1, 12'h000, 16'h8000);
        rd(12'h000, 32'h0000);
        // bus busy while sending, else the idle level clears the flag
        bus_idle <= 1'b0;
        pulse(2);
        rd(12'h008, 32'h0004);
        pulse(3);
        rd(12'h008, 32'h0000);
        pulse(0);
        rd(12'h008, 32'h0020);
        bus_idle <= 1'b1;
        // halt at idle, then sleep with auto-wake
        apb(1'b1, 12'h000, 16'h0002);
        wt(0, 1'b0, 12);
        rd(12'h008, 32'h0030);
        apb(1'b1, 12'h000, 16'h0082);
        apb(1'b1, 12'h000, 16'h00A0);
        wt(1, 1'b1, 10);
        node_start <= 1'b1;
        @(posedge pclk);
        node_start <= 1'b0;
        wt(1, 1'b0, 200);
        wt(0, 1'b1, 400);
        rd(12'h000, 32'h0080);
        // software reset, then bus-off auto-halt
        apb(1'b1, 12'h000, 16'h0081);
        rd(12'h008, 32'h0008);
        rd(12'h000, 32'h0001);
        apb(1'b1, 12'h000, 16'h4041);
        apb(1'b1, 12'h000, 16'h4040);
        wt(0, 1'b1, 600);
        busoff <= 1'b1;
        wt(0, 1'b0, 40);
        rd(12'h000, 32'h4042);
        busoff <= 1'b0;
        apb(1'b1, 12'h000, 16'h4040);
        wt(0, 1'b1, 600);
        end_of_test;
    end
endmodule
`default_nettype wire
